// *** rtl/mb_handler.sv ***
/*
  Request handler of the field network server: decodes function codes
  against a ten word input and ten word output image, answers beats or
  exceptions, counts host connections and blinks the status indicator.
  Assumes request framing and write data come from logic on I_SYS_CLK.
*/
`timescale 1ns/100ps
module mb_handler #(
  parameter int FLASH_ON_CYC    = mb_pkg::FLASH_ON_CYC,
  parameter int FLASH_GAP_CYC   = mb_pkg::FLASH_GAP_CYC,
  parameter int FLASH_PAUSE_CYC = mb_pkg::FLASH_PAUSE_CYC
) (
  input  wire logic          I_SYS_CLK,
  input  wire logic          I_ARST_N,
  input  wire logic          i_CE,
  input  wire logic          i_REQ_VALID,
  input  wire mb_pkg::req_t  i_REQ,
  output      logic          o_REQ_READY,
  input  wire logic          i_WVALID,
  input  wire mb_pkg::word_t i_WDATA,
  output      logic          o_WREADY,
  output      mb_pkg::rsp_t  o_RSP,
  input  wire mb_pkg::img_t  i_SLOT1,
  output      mb_pkg::img_t  o_SLOT2,
  input  wire logic          i_CONN_OPEN,
  input  wire logic          i_CONN_CLOSE,
  output      logic [2:0]    o_CONN_COUNT,
  output      logic          o_CONN_REFUSED,
  output      logic          o_NETWORK_STATUS_INDICATOR
);
  mb_pkg::st_t   state;
  mb_pkg::req_t  req;
  mb_pkg::img_t  in_snap;
  mb_pkg::img_t  out_buf;
  mb_pkg::word_t ptr;
  mb_pkg::word_t cnt;
  logic [31:0]   timer;
  logic [2:0]    grp;

  // function classes
  wire [7:0] fc       = req.fc;
  wire rd_bits  = fc == mb_pkg::FC_RD_COILS || fc == mb_pkg::FC_RD_DISC;
  wire rd_words = fc == mb_pkg::FC_RD_HOLD || fc == mb_pkg::FC_RD_INREG
               || fc == mb_pkg::FC_RW_REGS;
  wire wr_bits  = fc == mb_pkg::FC_WR_COIL || fc == mb_pkg::FC_WR_COILS;
  wire wr_single = fc == mb_pkg::FC_WR_COIL || fc == mb_pkg::FC_WR_REG
                || fc == mb_pkg::FC_MASK_WR;
  wire wr_multi = fc == mb_pkg::FC_WR_COILS || fc == mb_pkg::FC_WR_REGS
               || fc == mb_pkg::FC_RW_REGS;
  wire has_rd   = rd_bits || rd_words;
  wire has_wr   = wr_single || wr_multi;
  wire fc_ok    = has_rd || has_wr;

  // read side decode; code 3 picks its image by address
  wire rd_out = fc == mb_pkg::FC_RD_COILS
             || (fc == mb_pkg::FC_RD_HOLD
                 && req.addr >= mb_pkg::OUT_WORD_BASE);
  wire mb_pkg::word_t rd_base = rd_bits ? (rd_out ? mb_pkg::COIL_BASE
                                : mb_pkg::IN_BIT_BASE)
                              : (rd_out ? mb_pkg::OUT_WORD_BASE
                                : mb_pkg::IN_WORD_BASE);
  wire mb_pkg::word_t rd_span = rd_bits ? mb_pkg::BIT_SPAN
                                        : mb_pkg::WORD_SPAN;
  wire mb_pkg::word_t rd_max  = rd_bits ? mb_pkg::MAX_RD_BITS
                                        : mb_pkg::MAX_RD_REGS;
  wire [16:0] rd_end  = {1'b0, req.addr} + {1'b0, req.qty};
  wire [16:0] rd_lim  = {1'b0, rd_base} + {1'b0, rd_span};
  wire rd_addr_ok = req.addr >= rd_base && rd_end <= rd_lim;
  wire rd_qty_ok  = req.qty != 16'h0000 && req.qty <= rd_max;

  // write side decode: only the output image is writable
  wire mb_pkg::word_t wr_addr = fc == mb_pkg::FC_RW_REGS ? req.waddr
                                                         : req.addr;
  wire mb_pkg::word_t wr_qty  = wr_single ? 16'h0001
                              : fc == mb_pkg::FC_RW_REGS ? req.wqty
                                                         : req.qty;
  wire mb_pkg::word_t wr_base = wr_bits ? mb_pkg::COIL_BASE
                                        : mb_pkg::OUT_WORD_BASE;
  wire mb_pkg::word_t wr_span = wr_bits ? mb_pkg::BIT_SPAN
                                        : mb_pkg::WORD_SPAN;
  wire [16:0] wr_end  = {1'b0, wr_addr} + {1'b0, wr_qty};
  wire [16:0] wr_lim  = {1'b0, wr_base} + {1'b0, wr_span};
  wire wr_addr_ok = wr_addr >= wr_base && wr_end <= wr_lim;
  wire mb_pkg::word_t wr_max = fc == mb_pkg::FC_WR_COILS
                               ? mb_pkg::MAX_WR_BITS
                             : fc == mb_pkg::FC_WR_REGS
                               ? mb_pkg::MAX_WR_REGS
                               : mb_pkg::MAX_RW_WR;
  wire coil_val_ok = req.value == mb_pkg::COIL_ON
                  || req.value == mb_pkg::COIL_OFF;
  wire wr_qty_ok  = fc == mb_pkg::FC_WR_COIL ? coil_val_ok
                  : wr_single || (wr_qty != 16'h0000 && wr_qty <= wr_max);

  // exception priority: function, value, address
  wire qty_ok  = (!has_rd || rd_qty_ok) && (!has_wr || wr_qty_ok);
  wire addr_ok = (!has_rd || rd_addr_ok) && (!has_wr || wr_addr_ok);
  wire [7:0] exc = !fc_ok   ? mb_pkg::EXC_FUNC
                 : !qty_ok  ? mb_pkg::EXC_VALUE
                 : !addr_ok ? mb_pkg::EXC_ADDR
                 : mb_pkg::EXC_NONE;

  // element select; bits alias word storage sixteen to a word
  wire mb_pkg::word_t rd_off = ptr - rd_base;
  wire [3:0] rd_widx = rd_bits ? rd_off[7:4] : rd_off[3:0];
  wire mb_pkg::img_t  rd_img = rd_out ? out_buf : in_snap;
  wire mb_pkg::word_t rd_word = rd_img[rd_widx];
  wire mb_pkg::word_t rd_data = rd_bits
                              ? {15'h0000, rd_word[rd_off[3:0]]}
                              : rd_word;
  wire mb_pkg::word_t wr_off = ptr - wr_base;
  wire [3:0] wr_widx = wr_bits ? wr_off[7:4] : wr_off[3:0];
  wire mb_pkg::word_t wr_cur = out_buf[wr_widx];
  wire wr_bit_val = fc == mb_pkg::FC_WR_COIL
                  ? req.value == mb_pkg::COIL_ON : i_WDATA[0];
  wire mb_pkg::word_t bit_sel = 16'h0001 << wr_off[3:0];
  wire mb_pkg::word_t wr_word =
      wr_bits ? ((wr_cur & ~bit_sel) | (wr_bit_val ? bit_sel : 16'h0000))
    : fc == mb_pkg::FC_MASK_WR
      ? ((wr_cur & req.and_mask) | (req.value & ~req.and_mask))
    : fc == mb_pkg::FC_WR_REG ? req.value : i_WDATA;
  wire wr_take = state == mb_pkg::ST_WRITE
              && (wr_single || (i_WVALID && o_WREADY));

  // request sequencer
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state <= mb_pkg::ST_IDLE;
      req   <= '0;
      ptr   <= 16'h0000;
      cnt   <= 16'h0000;
    end else if (i_CE) begin
      unique case (state)
        mb_pkg::ST_IDLE: begin
          if (i_REQ_VALID && o_REQ_READY) begin
            req   <= i_REQ;
            state <= mb_pkg::ST_CHECK;
          end
        end
        mb_pkg::ST_CHECK: begin
          if (exc != mb_pkg::EXC_NONE) begin
            state <= mb_pkg::ST_IDLE;
          end else if (has_wr) begin
            ptr   <= wr_addr;
            cnt   <= wr_qty;
            state <= mb_pkg::ST_WRITE;
          end else begin
            ptr   <= req.addr;
            cnt   <= req.qty;
            state <= mb_pkg::ST_READ;
          end
        end
        mb_pkg::ST_WRITE: begin
          if (wr_take) begin
            ptr <= ptr + 16'h0001;
            cnt <= cnt - 16'h0001;
            if (cnt == 16'h0001 && has_rd) begin
              ptr   <= req.addr;
              cnt   <= req.qty;
              state <= mb_pkg::ST_READ;
            end else if (cnt == 16'h0001) begin
              state <= mb_pkg::ST_DONE;
            end
          end
        end
        mb_pkg::ST_READ: begin
          ptr <= ptr + 16'h0001;
          cnt <= cnt - 16'h0001;
          if (cnt == 16'h0001) begin
            state <= mb_pkg::ST_DONE;
          end
        end
        mb_pkg::ST_DONE: state <= mb_pkg::ST_IDLE;
      endcase
    end
  end

  // handshakes: ready for a request in idle, write data during writes
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_REQ_READY <= 1'b1;
      o_WREADY    <= 1'b0;
    end else if (i_CE) begin
      o_REQ_READY <= (state == mb_pkg::ST_IDLE && !i_REQ_VALID)
                  || (state == mb_pkg::ST_CHECK && exc != mb_pkg::EXC_NONE)
                  || state == mb_pkg::ST_DONE;
      o_WREADY <= (state == mb_pkg::ST_CHECK && exc == mb_pkg::EXC_NONE
                   && wr_multi)
               || (o_WREADY && !(wr_take && cnt == 16'h0001));
    end
  end

  // input snapshot at accept; written words held until the end
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      in_snap <= '0;
      out_buf <= mb_pkg::OUT_IMG_RST;
      o_SLOT2 <= mb_pkg::OUT_IMG_RST;
    end else if (i_CE) begin
      if (state == mb_pkg::ST_IDLE && i_REQ_VALID && o_REQ_READY)
        in_snap <= i_SLOT1;
      if (wr_take)
        out_buf[wr_widx] <= wr_word;
      if (state == mb_pkg::ST_DONE)
        o_SLOT2 <= out_buf;
    end
  end

  // answer beats: read data, write echo or exception
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_RSP <= '0;
    end else if (i_CE) begin
      o_RSP <= '0;
      if (state == mb_pkg::ST_CHECK && exc != mb_pkg::EXC_NONE)
        o_RSP <= '{1'b1, 1'b1, exc, 16'h0000};
      else if (state == mb_pkg::ST_READ)
        o_RSP <= '{1'b1, cnt == 16'h0001, mb_pkg::EXC_NONE, rd_data};
      else if (state == mb_pkg::ST_DONE && !has_rd)
        o_RSP <= '{1'b1, 1'b1, mb_pkg::EXC_NONE, wr_qty};
    end
  end

  // connection count, saturating at six
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_CONN_COUNT   <= 3'h0;
      o_CONN_REFUSED <= 1'b0;
    end else if (i_CE) begin
      o_CONN_REFUSED <= i_CONN_OPEN && !i_CONN_CLOSE
                     && o_CONN_COUNT == mb_pkg::MAX_CONN;
      if (i_CONN_OPEN && !i_CONN_CLOSE
          && o_CONN_COUNT != mb_pkg::MAX_CONN)
        o_CONN_COUNT <= o_CONN_COUNT + 3'h1;
      else if (i_CONN_CLOSE && !i_CONN_OPEN && o_CONN_COUNT != 3'h0)
        o_CONN_COUNT <= o_CONN_COUNT - 3'h1;
    end
  end

  // indicator: groups of flashes, then a long dark pause
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      timer <= 32'h0000_0000;
      grp   <= 3'h0;
      o_NETWORK_STATUS_INDICATOR <= 1'b0;
    end else if (i_CE) begin
      if (timer != 32'h0000_0000) begin
        timer <= timer - 32'h0000_0001;
      end else if (o_NETWORK_STATUS_INDICATOR) begin
        o_NETWORK_STATUS_INDICATOR <= 1'b0;
        grp   <= grp - 3'h1;
        timer <= grp == 3'h1 ? 32'(FLASH_PAUSE_CYC - 1)
                             : 32'(FLASH_GAP_CYC - 1);
      end else if (o_CONN_COUNT != 3'h0) begin
        o_NETWORK_STATUS_INDICATOR <= 1'b1;
        timer <= 32'(FLASH_ON_CYC - 1);
        if (grp == 3'h0)
          grp <= o_CONN_COUNT;
      end else begin
        grp <= 3'h0;
      end
    end
  end

  // checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);

  AST_CONN_MAX: assert property (o_CONN_COUNT <= mb_pkg::MAX_CONN)
    else $error("connection count above limit");
  AST_DARK_IDLE: assert property (
    o_CONN_COUNT == 3'h0 && !o_NETWORK_STATUS_INDICATOR && grp == 3'h0
    |=> !o_NETWORK_STATUS_INDICATOR)
    else $error("indicator lit with no connection");
  AST_PAUSE: assert property (
    i_CE && o_NETWORK_STATUS_INDICATOR && timer == 32'h0000_0000
    && grp == 3'h1 |=> timer == 32'(FLASH_PAUSE_CYC - 1)
    && !o_NETWORK_STATUS_INDICATOR)
    else $error("pause after group wrong");
  AST_EXC_FUNC: assert property (
    i_CE && state == mb_pkg::ST_CHECK && !fc_ok
    |=> o_RSP.valid && o_RSP.exc == mb_pkg::EXC_FUNC)
    else $error("unsupported code not refused");
  AST_EXC_ADDR: assert property (
    i_CE && state == mb_pkg::ST_CHECK && fc == mb_pkg::FC_RD_INREG
    && req.qty == 16'h0001 && req.addr >= mb_pkg::WORD_SPAN
    |=> o_RSP.exc == mb_pkg::EXC_ADDR)
    else $error("address outside image not refused");
  AST_EXC_VALUE: assert property (
    i_CE && state == mb_pkg::ST_CHECK && fc_ok && has_rd
    && req.qty == 16'h0000 |=> o_RSP.exc == mb_pkg::EXC_VALUE)
    else $error("zero quantity not refused");
  AST_COIL_BASE: assert property (
    i_CE && state == mb_pkg::ST_CHECK && fc == mb_pkg::FC_WR_COIL
    && req.addr == mb_pkg::COIL_BASE && req.value == mb_pkg::COIL_ON
    ##1 i_CE ##1 i_CE |=> o_SLOT2[0][0])
    else $error("first coil not bit zero of first word");
  AST_IN_BIT0: assert property (
    i_CE && state == mb_pkg::ST_READ && fc == mb_pkg::FC_RD_DISC
    && ptr == 16'h0000 |=> o_RSP.data == {15'h0000, in_snap[0][0]})
    else $error("input bit zero misread");
  AST_IN_WORD: assert property (
    i_CE && state == mb_pkg::ST_READ && !rd_out && !rd_bits
    && ptr < mb_pkg::WORD_SPAN |=> o_RSP.data == $past(in_snap[ptr[3:0]]))
    else $error("input word not from snapshot");
  AST_HOLD_OUT: assert property (
    state != mb_pkg::ST_DONE |=> $stable(o_SLOT2))
    else $error("output image changed mid request");
  AST_MASK: assert property (
    i_CE && state == mb_pkg::ST_WRITE && fc == mb_pkg::FC_MASK_WR
    |=> out_buf[$past(wr_widx)] == (($past(wr_cur) & req.and_mask)
        | (req.value & ~req.and_mask)))
    else $error("mask write result wrong");

  COV_RW: cover property (
    state == mb_pkg::ST_DONE && fc == mb_pkg::FC_RW_REGS);
  COV_EXC: cover property (o_RSP.valid && o_RSP.exc != 8'h00);
  COV_PAUSE: cover property (
    $fell(o_NETWORK_STATUS_INDICATOR) && o_CONN_COUNT == 3'h2);
endmodule

// *** rtl/mb_pkg.sv ***
/*
  Shared types and constants of the request handler for the field
  network server: function and exception codes, image layout, limits,
  indicator timing and the request and answer carriers.
  Assumes a 20 MHz system clock.
*/
package mb_pkg;
  // process image: ten words each way, twenty bytes
  localparam int IMG_WORDS = 10;
  typedef logic [15:0]                word_t;
  typedef logic [IMG_WORDS-1:0][15:0] img_t;
  localparam img_t OUT_IMG_RST = '0;

  // address bases and spans
  localparam word_t IN_WORD_BASE  = 16'h0000;
  localparam word_t IN_BIT_BASE   = 16'h0000;
  localparam word_t OUT_WORD_BASE = 16'h0400;
  localparam word_t COIL_BASE     = 16'h4000;
  localparam word_t WORD_SPAN     = 16'h000A;
  localparam word_t BIT_SPAN      = 16'h00A0;

  // function codes
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_DISC  = 8'h02;
  localparam logic [7:0] FC_RD_HOLD  = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL  = 8'h05;
  localparam logic [7:0] FC_WR_REG   = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS  = 8'h10;
  localparam logic [7:0] FC_MASK_WR  = 8'h16;
  localparam logic [7:0] FC_RW_REGS  = 8'h17;

  // exception codes
  localparam logic [7:0] EXC_NONE  = 8'h00;
  localparam logic [7:0] EXC_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ADDR  = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // quantity limits and single coil values
  localparam word_t MAX_RD_BITS = 16'h07D0;
  localparam word_t MAX_RD_REGS = 16'h007D;
  localparam word_t MAX_WR_BITS = 16'h07B0;
  localparam word_t MAX_WR_REGS = 16'h007B;
  localparam word_t MAX_RW_WR   = 16'h0079;
  localparam word_t COIL_ON     = 16'hFF00;
  localparam word_t COIL_OFF    = 16'h0000;

  localparam logic [2:0] MAX_CONN = 3'h6;

  // indicator timing
  localparam longint CLK_HZ      = 20000000;
  localparam longint FLASH_ON_MS    = 250;
  localparam longint FLASH_GAP_MS   = 250;
  localparam longint FLASH_PAUSE_MS = 2000;
  localparam int FLASH_ON_CYC    = int'((FLASH_ON_MS * CLK_HZ) / 1000);
  localparam int FLASH_GAP_CYC   = int'((FLASH_GAP_MS * CLK_HZ) / 1000);
  localparam int FLASH_PAUSE_CYC = int'((FLASH_PAUSE_MS * CLK_HZ) / 1000);

  typedef struct packed {
    logic [7:0] fc;
    word_t      addr;      // read start, or single/multi write start
    word_t      qty;       // read count, or write count
    word_t      waddr;     // write start of combined read/write
    word_t      wqty;      // write count of combined read/write
    word_t      and_mask;  // mask write
    word_t      value;     // single write value or or-mask
  } req_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] exc;
    word_t      data;
  } rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CHECK = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b011,
    ST_DONE  = 3'b100
  } st_t;
endpackage

// *** tb/host_model.sv ***
/*
  host controller model: issues requests, write beats and connection
  events. assumes the handler's ready and write-ready handshakes.
*/
`timescale 1ns/100ps
module host_model (
  input  wire logic          clk,
  input  wire logic          i_ready,
  input  wire logic          i_wready,
  output      logic          o_valid,
  output      mb_pkg::req_t  o_req,
  output      logic          o_wvalid,
  output      mb_pkg::word_t o_wdata,
  output      logic          o_open,
  output      logic          o_close
);
  // quiet levels at time zero
  initial begin
    o_valid = 1'b0;
    o_req = '0;
    o_wvalid = 1'b0;
    o_wdata = '0;
    o_open = 1'b0;
    o_close = 1'b0;
  end

  // released fields keep changing so stale values never pass
  always @(negedge clk) begin
    if (!o_valid) o_req <= ~o_req;
    if (!o_wvalid) o_wdata <= ~o_wdata;
  end

  // one request, then its write beats, each held until taken
  task automatic send(input mb_pkg::req_t r, input mb_pkg::word_t w[$]);
    int k;
    @(posedge clk);
    o_valid <= 1'b1;
    o_req   <= r;
    do @(posedge clk); while (i_ready !== 1'b1);
    o_valid <= 1'b0;
    for (k = 0; k < w.size(); k++) begin
      o_wvalid <= 1'b1;
      o_wdata  <= w[k];
      do @(posedge clk); while (i_wready !== 1'b1);
    end
    o_wvalid <= 1'b0;
  endtask

  // one-cycle open or close event
  task automatic conn(input logic open);
    @(posedge clk);
    o_open  <= open;
    o_close <= !open;
    @(posedge clk);
    o_open  <= 1'b0;
    o_close <= 1'b0;
  endtask
endmodule

// *** tb/tb_top.sv ***
/*
  self-checking bench of the request handler: host model drives,
  a monitor checks answer beats against a queue of notes.
  assumes short indicator counts set here.
*/
`timescale 1ns/100ps
module tb_top;
  localparam int ON    = 4;
  localparam int GAP   = 3;
  localparam int PAUSE = 20;
  logic          clk = 1'b0;
  logic          arst_n = 1'b0;
  logic          seen_ref = 1'b0;
  logic          rv, wv, op, cl, rdy, wrdy, refd, led;
  logic [2:0]    cnt;
  mb_pkg::req_t  req;
  mb_pkg::word_t wd;
  mb_pkg::rsp_t  rsp;
  mb_pkg::img_t  img_in, img_out, slot2;
  mb_pkg::rsp_t  q[$];
  int            errors = 0;
  int            n_tests = 0;

  always #25 clk = ~clk;

  mb_handler #(.FLASH_ON_CYC(ON), .FLASH_GAP_CYC(GAP),
    .FLASH_PAUSE_CYC(PAUSE)) dut (
    .I_SYS_CLK(clk), .I_ARST_N(arst_n), .i_CE(1'b1), .i_REQ_VALID(rv),
    .i_REQ(req), .o_REQ_READY(rdy), .i_WVALID(wv), .i_WDATA(wd),
    .o_WREADY(wrdy), .o_RSP(rsp), .i_SLOT1(img_in), .o_SLOT2(slot2),
    .i_CONN_OPEN(op), .i_CONN_CLOSE(cl), .o_CONN_COUNT(cnt),
    .o_CONN_REFUSED(refd), .o_NETWORK_STATUS_INDICATOR(led));

  host_model h (.clk(clk), .i_ready(rdy), .i_wready(wrdy), .o_valid(rv),
    .o_req(req), .o_wvalid(wv), .o_wdata(wd), .o_open(op), .o_close(cl));

  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp_rsp(input mb_pkg::rsp_t got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected answer at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_val(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // take the oldest note off the queue at each answer beat
  always @(posedge clk) begin
    if (refd === 1'b1) seen_ref <= 1'b1;
    if (rsp.valid === 1'b1) begin
      if (q.size() == 0) cmp_rsp(rsp, '0);
      else cmp_rsp(rsp, q.pop_front());
    end
  end

  task automatic ex(input logic [7:0] e, input mb_pkg::word_t d, logic l);
    q.push_back({1'b1, l, e, d});
  endtask

  task automatic exw(input mb_pkg::img_t im, input int a, n);
    for (int k = 0; k < n; k++) ex(8'h00, im[a+k], k == n - 1);
  endtask

  task automatic exb(input mb_pkg::img_t im, input int a, n);
    for (int k = 0; k < n; k++)
      ex(8'h00, {15'h0000, im[(a+k)/16][(a+k)%16]}, k == n - 1);
  endtask

  function automatic mb_pkg::req_t mk(input logic [7:0] fc,
                                      input mb_pkg::word_t a, n, v);
    mk = '0;
    mk.fc = fc;
    mk.addr = a;
    mk.qty = n;
    mk.value = v;
  endfunction

  // send, wait for every noted beat, let the image commit
  task automatic run(input mb_pkg::req_t r, input mb_pkg::word_t w[$]);
    int k;
    h.send(r, w);
    for (k = 0; k < 300 && q.size() != 0; k++) @(posedge clk);
    if (q.size() != 0) errors++;
    q.delete();
    repeat (3) @(posedge clk);
  endtask

  task automatic bad(input mb_pkg::req_t r, input logic [7:0] e);
    mb_pkg::word_t none[$];
    ex(e, 16'h0000, 1'b1);
    run(r, none);
  endtask

  task automatic chk_img();
    for (int k = 0; k < 10; k++) cmp_val(slot2[k], img_out[k]);
  endtask

  // rises counted between two dark pauses
  task automatic flashes(output int n, output int t);
    int low;
    bit go;
    low = 0;
    go = 1'b0;
    for (t = 0; t < 400 && !go; t++) begin
      @(posedge clk);
      go = led === 1'b1 && low >= PAUSE;
      low = (led === 1'b0) ? low + 1 : 0;
    end
    if (!go) errors++;
    low = 0;
    n = 1;
    for (t = 0; t < 400 && low < PAUSE; t++) begin
      @(posedge clk);
      if (led === 1'b1 && low > 0) n++;
      low = (led === 1'b0) ? low + 1 : 0;
    end
  endtask

  // main sequence
  initial begin
    mb_pkg::word_t none[$];
    mb_pkg::word_t w[$];
    mb_pkg::req_t r;
    int n, t;
    void'($urandom(32'h5FB3432D));
    for (int k = 0; k < 10; k++) img_in[k] = 16'($urandom);
    img_out = '0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    cmp_val(16'(rdy), 16'h0001);
    chk_img();
    exw(img_in, 0, 10);
    run(mk(mb_pkg::FC_RD_INREG, 16'h0000, 16'h000A, 16'h0000), none);
    exb(img_in, 16, 5);
    run(mk(mb_pkg::FC_RD_DISC, 16'h0010, 16'h0005, 16'h0000), none);
    w = {16'($urandom), 16'($urandom)};
    img_out[3] = w[0];
    img_out[4] = w[1];
    ex(8'h00, 16'h0002, 1'b1);
    run(mk(mb_pkg::FC_WR_REGS, 16'h0403, 16'h0002, 16'h0000), w);
    chk_img();
    exw(img_out, 3, 2);
    run(mk(mb_pkg::FC_RD_HOLD, 16'h0403, 16'h0002, 16'h0000), none);
    exw(img_in, 8, 2);
    run(mk(mb_pkg::FC_RD_HOLD, 16'h0008, 16'h0002, 16'h0000), none);
    img_out[0] = 16'hA5C3;
    ex(8'h00, 16'h0001, 1'b1);
    run(mk(mb_pkg::FC_WR_REG, 16'h0400, 16'h0000, 16'hA5C3), none);
    r = mk(mb_pkg::FC_MASK_WR, 16'h0400, 16'h0000, 16'h3C0F);
    r.and_mask = 16'hF0F0;
    img_out[0] = (img_out[0] & 16'hF0F0) | (16'h3C0F & ~16'hF0F0);
    ex(8'h00, 16'h0001, 1'b1);
    run(r, none);
    chk_img();
    img_out[1][1] = 1'b1;
    ex(8'h00, 16'h0001, 1'b1);
    run(mk(mb_pkg::FC_WR_COIL, 16'h4011, 16'h0000, 16'hFF00), none);
    img_out[0][0] = 1'b0;
    ex(8'h00, 16'h0001, 1'b1);
    run(mk(mb_pkg::FC_WR_COIL, 16'h4000, 16'h0000, 16'h0000), none);
    chk_img();
    img_out[0][0] = 1'b1;
    ex(8'h00, 16'h0001, 1'b1);
    run(mk(mb_pkg::FC_WR_COIL, 16'h4000, 16'h0000, 16'hFF00), none);
    img_out[1][14] = 1'b1;
    img_out[1][15] = 1'b0;
    img_out[2][0] = 1'b1;
    ex(8'h00, 16'h0003, 1'b1);
    w = {16'h0001, 16'h0000, 16'h0001};
    run(mk(mb_pkg::FC_WR_COILS, 16'h401E, 16'h0003, 16'h0000), w);
    chk_img();
    exb(img_out, 14, 20);
    run(mk(mb_pkg::FC_RD_COILS, 16'h400E, 16'h0014, 16'h0000), none);
    r = mk(mb_pkg::FC_RW_REGS, 16'h0000, 16'h0002, 16'h0000);
    r.waddr = 16'h0405;
    r.wqty = 16'h0001;
    w = {16'($urandom)};
    img_out[5] = w[0];
    exw(img_in, 0, 2);
    fork
      run(r, w);
      begin
        repeat (3) @(posedge clk);
        img_in[0] <= ~img_in[0];
      end
    join
    chk_img();
    exw(img_in, 0, 1);
    run(mk(mb_pkg::FC_RD_INREG, 16'h0000, 16'h0001, 16'h0000), none);
    bad(mk(8'h07, 16'h0000, 16'h0001, 16'h0000), 8'h01);
    bad(mk(8'h2B, 16'h0000, 16'h0001, 16'h0000), 8'h01);
    bad(mk(mb_pkg::FC_RD_INREG, 16'h000A, 16'h0001, 16'h0000), 8'h02);
    bad(mk(mb_pkg::FC_RD_HOLD, 16'h0400, 16'h000B, 16'h0000), 8'h02);
    bad(mk(mb_pkg::FC_WR_REG, 16'h040A, 16'h0000, 16'h1234), 8'h02);
    bad(mk(mb_pkg::FC_RD_HOLD, 16'h0400, 16'h0000, 16'h0000), 8'h03);
    bad(mk(mb_pkg::FC_WR_COIL, 16'h4000, 16'h0000, 16'h1234), 8'h03);
    chk_img();
    repeat (7) h.conn(1'b1);
    repeat (2) @(posedge clk);
    cmp_val(16'(cnt), 16'h0006);
    cmp_val(16'(seen_ref), 16'h0001);
    flashes(n, t);
    cmp_val(16'(n), 16'h0006);
    repeat (4) h.conn(1'b0);
    flashes(n, t);
    flashes(n, t);
    cmp_val(16'(n), 16'h0002);
    cmp_val(16'(t < 400), 16'h0001);
    @(posedge clk);
    cmp_val(16'(led), 16'h0001);
    final_report();
  end

  // watchdog for a hung handshake
  initial begin
    #(50 * 20000);
    errors++;
    final_report();
  end
endmodule
